// ### core/video_timing_irq_pkg.sv
// package: register map, field layout, reset values and stream carriers for video timing csr
package video_timing_irq_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] line_length_low_addr = 8'h20;
    localparam logic [7:0] line_length_high_addr = 8'h21;
    localparam logic [7:0] test_vertical_size_low_addr = 8'h24;
    localparam logic [7:0] test_vertical_size_high_addr = 8'h25;
    localparam logic [7:0] sync_delay_low_addr = 8'h28;
    localparam logic [7:0] sync_delay_high_addr = 8'h29;
    localparam logic [7:0] hsync_width_low_addr = 8'h2c;
    localparam logic [7:0] hsync_width_high_addr = 8'h2d;
    localparam logic [7:0] vsync_width_low_addr = 8'h30;
    localparam logic [7:0] vsync_width_high_addr = 8'h31;
    localparam logic [7:0] horiz_back_porch_addr = 8'h34;
    localparam logic [7:0] vert_back_porch_addr = 8'h36;
    localparam logic [7:0] horiz_front_porch_addr = 8'h38;
    localparam logic [7:0] vert_front_porch_addr = 8'h3a;
    localparam logic [7:0] pattern_control_addr = 8'h3c;
    localparam logic [7:0] interrupt_output_enable_addr = 8'he0;
    localparam logic [7:0] error_interrupt_mask_addr = 8'he1;
    localparam logic [7:0] error_status_flags_addr = 8'he5;

    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int pattern_generator_on_bit = 4;
    localparam int irq_drive_enable_bit = 0;
    localparam logic [7:0] reg_reset_value = 8'h00;
    localparam logic [7:0] error_mask_used_bits = 8'hfd;
    localparam logic [7:0] error_status_reset_value = 8'h01;
    localparam int pipeline_latency_cycles = 10;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csr_req_type;

    typedef struct packed {
        logic hsync;
        logic vsync;
        logic de;
        logic [23:0] pixel;
    } video_type;

    typedef struct packed {
        logic sync_sequence_error;
        logic payload_checksum_error;
        logic header_uncorrectable_error;
        logic header_corrected_error;
        logic low_level_protocol_error;
        logic leader_sequence_bit_error;
    } error_events_type;

endpackage : video_timing_irq_pkg

// ### core/video_timing_irq_csr.sv
// video timing registers, test pattern generator, sync delay and error interrupt
// ****************************************
// ****************************************
`timescale 1ns/1ps
`default_nettype none

module video_timing_irq_csr
    import video_timing_irq_pkg::*;
#(
    parameter int delay_depth = 4096
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire csr_req_type csr_req,
    output logic [7:0] csr_rdata,
    input wire video_type video_in,
    input wire error_events_type error_events,
    input wire logic pll_locked,
    output video_type video_out,
    output logic irq_o,
    output logic irq_oe
);

    // ****************************************
    // state
    // ****************************************
    typedef enum logic [1:0] {seg_sync, seg_back, seg_active, seg_front} seg_type;

    typedef struct packed {
        logic [7:0] line_length_low;
        logic [3:0] line_length_high;
        logic [7:0] test_vertical_size_low;
        logic [3:0] test_vertical_size_high;
        logic [7:0] sync_delay_low;
        logic [3:0] sync_delay_high;
        logic [7:0] hsync_width_low;
        logic [1:0] hsync_width_high;
        logic [7:0] vsync_width_low;
        logic [1:0] vsync_width_high;
        logic [7:0] horiz_back_porch;
        logic [7:0] vert_back_porch;
        logic [7:0] horiz_front_porch;
        logic [7:0] vert_front_porch;
        logic pattern_generator_on;
        logic irq_drive_enable;
        logic [7:0] error_interrupt_mask;
        logic [7:0] error_status_flags;
        logic pll_locked_prev;
        logic [7:0] rdata;
        seg_type hseg;
        seg_type vseg;
        logic [11:0] hcnt;
        logic [11:0] vcnt;
        logic [11:0] wr_ptr;
        logic irq_level;
        logic [pipeline_latency_cycles*27-1:0] pipe;
        video_type out;
    } state_type;

    state_type state_r;
    state_type state_nxt;
    logic [1:0] sync_line [delay_depth];
    logic [1:0] delayed_sync;
    logic [11:0] rd_ptr;
    video_type gen_video;
    video_type pipe_tail;

    function automatic logic [7:0] read_mux(input state_type s, input logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            line_length_low_addr: d = s.line_length_low;
            line_length_high_addr: d = {4'h0, s.line_length_high};
            test_vertical_size_low_addr: d = s.test_vertical_size_low;
            test_vertical_size_high_addr: d = {4'h0, s.test_vertical_size_high};
            sync_delay_low_addr: d = s.sync_delay_low;
            sync_delay_high_addr: d = {4'h0, s.sync_delay_high};
            hsync_width_low_addr: d = s.hsync_width_low;
            hsync_width_high_addr: d = {6'h00, s.hsync_width_high};
            vsync_width_low_addr: d = s.vsync_width_low;
            vsync_width_high_addr: d = {6'h00, s.vsync_width_high};
            horiz_back_porch_addr: d = s.horiz_back_porch;
            vert_back_porch_addr: d = s.vert_back_porch;
            horiz_front_porch_addr: d = s.horiz_front_porch;
            vert_front_porch_addr: d = s.vert_front_porch;
            pattern_control_addr: d = 8'(32'(s.pattern_generator_on) << pattern_generator_on_bit);
            interrupt_output_enable_addr: d = {7'h00, s.irq_drive_enable};
            error_interrupt_mask_addr: d = s.error_interrupt_mask;
            error_status_flags_addr: d = s.error_status_flags;
            default: d = 8'h00;
        endcase
        return d;
    endfunction : read_mux

    // length of a segment; zero-length segments are skipped after one cycle
    function automatic logic [11:0] seg_len(input seg_type g, input logic [11:0] sy,
                                            input logic [11:0] bp, input logic [11:0] ac,
                                            input logic [11:0] fp);
        logic [11:0] n;
        n = 12'h000;
        unique case (g)
            seg_sync: n = sy;
            seg_back: n = bp;
            seg_active: n = ac;
            seg_front: n = fp;
        endcase
        return n;
    endfunction : seg_len

    // ****************************************
    // sync delay line
    // ****************************************
    // memory kept outside the state struct so it maps to ram
    assign rd_ptr = state_r.wr_ptr - {state_r.sync_delay_high, state_r.sync_delay_low};
    assign delayed_sync = sync_line[rd_ptr[$clog2(delay_depth)-1:0]];
    always_ff @(posedge clk) begin
        sync_line[state_r.wr_ptr[$clog2(delay_depth)-1:0]] <= {video_in.hsync, video_in.vsync};
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [11:0] hlen;
        logic [11:0] vlen;
        logic hdone;
        logic [7:0] setv;
        logic [7:0] clrv;
        state_nxt = state_r;
        setv = 8'h00;
        clrv = 8'h00;
        hlen = seg_len(state_r.hseg, {2'b00, state_r.hsync_width_high, state_r.hsync_width_low},
                       {4'h0, state_r.horiz_back_porch},
                       {state_r.line_length_high, state_r.line_length_low},
                       {4'h0, state_r.horiz_front_porch});
        vlen = seg_len(state_r.vseg, {2'b00, state_r.vsync_width_high, state_r.vsync_width_low},
                       {4'h0, state_r.vert_back_porch},
                       {state_r.test_vertical_size_high, state_r.test_vertical_size_low},
                       {4'h0, state_r.vert_front_porch});
        hdone = (state_r.hcnt + 12'h001 >= hlen);

        // register writes
        if (csr_req.wr) begin
            unique case (csr_req.addr)
                line_length_low_addr: state_nxt.line_length_low = csr_req.wdata;
                line_length_high_addr: state_nxt.line_length_high = csr_req.wdata[3:0];
                test_vertical_size_low_addr: state_nxt.test_vertical_size_low = csr_req.wdata;
                test_vertical_size_high_addr: state_nxt.test_vertical_size_high = csr_req.wdata[3:0];
                sync_delay_low_addr: state_nxt.sync_delay_low = csr_req.wdata;
                sync_delay_high_addr: state_nxt.sync_delay_high = csr_req.wdata[3:0];
                hsync_width_low_addr: state_nxt.hsync_width_low = csr_req.wdata;
                hsync_width_high_addr: state_nxt.hsync_width_high = csr_req.wdata[1:0];
                vsync_width_low_addr: state_nxt.vsync_width_low = csr_req.wdata;
                vsync_width_high_addr: state_nxt.vsync_width_high = csr_req.wdata[1:0];
                horiz_back_porch_addr: state_nxt.horiz_back_porch = csr_req.wdata;
                vert_back_porch_addr: state_nxt.vert_back_porch = csr_req.wdata;
                horiz_front_porch_addr: state_nxt.horiz_front_porch = csr_req.wdata;
                vert_front_porch_addr: state_nxt.vert_front_porch = csr_req.wdata;
                pattern_control_addr:
                    state_nxt.pattern_generator_on = csr_req.wdata[pattern_generator_on_bit];
                interrupt_output_enable_addr:
                    state_nxt.irq_drive_enable = csr_req.wdata[irq_drive_enable_bit];
                error_interrupt_mask_addr:
                    state_nxt.error_interrupt_mask = csr_req.wdata & error_mask_used_bits;
                default: ;
            endcase
        end
        if (csr_req.rd) begin
            state_nxt.rdata = read_mux(state_r, csr_req.addr);
        end

        // status flags: set wins over the write-one clear
        clrv = (csr_req.wr && csr_req.addr == error_status_flags_addr) ? csr_req.wdata : 8'h00;
        setv = {error_events.sync_sequence_error,
                error_events.payload_checksum_error,
                error_events.header_uncorrectable_error,
                error_events.header_corrected_error,
                error_events.low_level_protocol_error,
                error_events.leader_sequence_bit_error,
                1'b0,
                state_r.pll_locked_prev && !pll_locked};
        state_nxt.error_status_flags = (state_r.error_status_flags & ~clrv) | setv;
        state_nxt.irq_level = |(state_nxt.error_status_flags
                                & state_nxt.error_interrupt_mask);
        state_nxt.pll_locked_prev = pll_locked;

        // pattern timing: counters only run while generating
        if (state_r.pattern_generator_on) begin
            if (hdone) begin
                state_nxt.hcnt = 12'h000;
                state_nxt.hseg = seg_type'(2'(state_r.hseg + 2'd1));
                if (state_r.hseg == seg_front) begin
                    if (state_r.vcnt + 12'h001 >= vlen) begin
                        state_nxt.vcnt = 12'h000;
                        state_nxt.vseg = seg_type'(2'(state_r.vseg + 2'd1));
                    end else begin
                        state_nxt.vcnt = state_r.vcnt + 12'h001;
                    end
                end
            end else begin
                state_nxt.hcnt = state_r.hcnt + 12'h001;
            end
        end else begin
            state_nxt.hseg = seg_sync;
            state_nxt.vseg = seg_sync;
            state_nxt.hcnt = 12'h000;
            state_nxt.vcnt = 12'h000;
        end

        // sync delay bookkeeping and output pipeline
        state_nxt.wr_ptr = state_r.wr_ptr + 12'h001;
        state_nxt.pipe = {state_r.pipe[pipeline_latency_cycles*27-28:0],
                          video_in.de, video_in.pixel, delayed_sync};
        state_nxt.out = state_r.pattern_generator_on ? gen_video : pipe_tail;
    end

    // unpack the pipeline tail: syncs have passed the delay line already
    assign pipe_tail.hsync = state_r.pipe[pipeline_latency_cycles*27-26];
    assign pipe_tail.vsync = state_r.pipe[pipeline_latency_cycles*27-27];
    assign pipe_tail.de = state_r.pipe[pipeline_latency_cycles*27-1];
    assign pipe_tail.pixel = state_r.pipe[pipeline_latency_cycles*27-2 -: 24];

    // colour bars from the horizontal position
    assign gen_video.hsync = (state_r.hseg == seg_sync);
    assign gen_video.vsync = (state_r.vseg == seg_sync);
    assign gen_video.de = (state_r.hseg == seg_active) && (state_r.vseg == seg_active);
    assign gen_video.pixel = gen_video.de ?
        {{8{state_r.hcnt[7]}}, {8{state_r.hcnt[6]}}, {8{state_r.hcnt[5]}}} : 24'h000000;

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= '0;
            state_r.error_status_flags <= error_status_reset_value;
            state_r.hseg <= seg_sync;
            state_r.vseg <= seg_sync;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign csr_rdata = state_r.rdata;
    assign video_out = state_r.out;
    // pin idles high-impedance; oe high only when enabled
    assign irq_oe = state_r.irq_drive_enable;
    // level taken from a flop so the pin cannot glitch while flags and mask change together
    assign irq_o = state_r.irq_level;

endmodule : video_timing_irq_csr

`default_nettype wire

// ### test/video_timing_irq_checker.sv
// checker: port-level assertions for the video timing register block
`timescale 1ns/1ps
`default_nettype none
module video_timing_irq_checker
    import video_timing_irq_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire csr_req_type csr_req,
    input wire logic [7:0] csr_rdata,
    input wire video_type video_in,
    input wire error_events_type error_events,
    input wire logic pll_locked,
    input wire video_type video_out,
    input wire logic irq_o,
    input wire logic irq_oe
);
    logic [7:0] mask_r;
    logic pat_r;
    logic [3:0] calm_r;
    logic mwr;
    assign mwr = csr_req.wr && csr_req.addr == error_interrupt_mask_addr;
    // calm_r waits out the pipeline after the pattern is switched off
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mask_r <= 8'h00;
            pat_r <= 1'b0;
            calm_r <= 4'h0;
        end else begin
            if (mwr) begin
                mask_r <= csr_req.wdata;
            end
            if (csr_req.wr && csr_req.addr == pattern_control_addr) begin
                pat_r <= csr_req.wdata[pattern_generator_on_bit];
            end
            calm_r <= pat_r ? 4'h0 : calm_r + {3'h0, calm_r != 4'hf};
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    chk_oe_follows: assert property (
        csr_req.wr && csr_req.addr == interrupt_output_enable_addr
        |=> irq_oe == $past(csr_req.wdata[irq_drive_enable_bit]))
        else $error("irq drive enable not taken from its write");
    chk_oe_reset: assert property ($fell(sys_rst) |-> !irq_oe)
        else $error("irq pin driven right after reset");
    chk_event_irq: assert property (
        |({error_events, 2'b00} & mask_r) && !mwr |=> irq_o)
        else $error("enabled error event did not raise irq");
    chk_pll_irq: assert property (
        $fell(pll_locked) && mask_r[0] && !mwr |=> irq_o)
        else $error("pll unlock did not raise irq");
    chk_mask_quiet: assert property (mask_r == 8'h00 |-> !irq_o)
        else $error("irq with every source masked");
    chk_mask_read: assert property (
        csr_req.rd && !csr_req.wr && csr_req.addr == error_interrupt_mask_addr
        |=> csr_rdata == ($past(mask_r) & error_mask_used_bits))
        else $error("mask readback wrong");
    chk_unmapped_read: assert property (
        csr_req.rd && csr_req.addr == 8'h00 |=> csr_rdata == 8'h00)
        else $error("unmapped address read nonzero");
    chk_video_pass: assert property (
        calm_r == 4'hf |-> video_out.de == $past(video_in.de, 11)
        && video_out.pixel == $past(video_in.pixel, 11))
        else $error("normal video not passed with fixed latency");
    cover property (irq_o && irq_oe);
    cover property ($rose(video_out.vsync));
    cover property (csr_req.wr && csr_req.addr == error_status_flags_addr);
endmodule : video_timing_irq_checker
`default_nettype wire

// ### test/csr_host_model.sv
// host model: register accesses on the strobe port, driven at the falling edge
`timescale 1ns/1ps
`default_nettype none
module csr_host_model
    import video_timing_irq_pkg::*;
(
    input wire logic clk,
    output var csr_req_type csr_req,
    input wire logic [7:0] csr_rdata
);
    initial csr_req = '0;
    // released lines show the inverse of the last value, so stale data never passes
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(negedge clk);
        csr_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk);
        q = csr_rdata;
        csr_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : access
endmodule : csr_host_model
`default_nettype wire

// ### test/tb_top.sv
// testbench: registers, status flags, interrupt, video path and test pattern
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import video_timing_irq_pkg::*;
;
    localparam logic [7:0] regs [17] = '{8'h20, 8'h21, 8'h24, 8'h25, 8'h28, 8'h29, 8'h2c,
        8'h2d, 8'h30, 8'h31, 8'h34, 8'h36, 8'h38, 8'h3a, 8'h3c, 8'he0, 8'he1};
    // 14 clocks a line, 260 lines a frame, 257 active lines
    localparam logic [15:0] cfg [16] = '{16'h2c03, 16'h2d00, 16'h3001, 16'h3100, 16'h3402,
        16'h3601, 16'h3804, 16'h3a01, 16'h2005, 16'h2100, 16'h2401, 16'h2501,
        16'h2828, 16'h2900, 16'he000, 16'h3c00};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    csr_req_type csr_req;
    logic [7:0] csr_rdata;
    video_type video_in = '0;
    error_events_type error_events = '0;
    logic pll_locked = 1'b1;
    video_type video_out;
    logic irq_o;
    logic irq_oe;
    video_type hist [64];
    integer seed = 32'h4093;
    integer fail_count = 0;
    integer comparisons = 0;
    integer cycles = 0;
    integer i;
    integer n;
    integer lines;
    integer gap;
    logic [7:0] q;
    logic [7:0] w;
    logic [7:0] m;
    logic [7:0] b;
    logic pde;
    always #50 clk = ~clk;
    video_timing_irq_csr #(.delay_depth(64)) i_dut (.clk(clk), .sys_rst(sys_rst),
        .csr_req(csr_req), .csr_rdata(csr_rdata), .video_in(video_in),
        .error_events(error_events), .pll_locked(pll_locked), .video_out(video_out),
        .irq_o(irq_o), .irq_oe(irq_oe));
    csr_host_model i_host (.clk(clk), .csr_req(csr_req), .csr_rdata(csr_rdata));
    always @(negedge clk) video_in <= video_type'(27'($random(seed)));
    always @(posedge clk) begin
        for (int k = 63; k > 0; k--) hist[k] <= hist[k - 1];
        hist[0] <= video_in;
        cycles <= cycles + 1;
        // ceiling covers two full pattern frames plus register traffic
        if (cycles == 20000) begin
            fail_count++;
            final_report();
        end
    end
    function automatic logic [7:0] used_bits(input logic [7:0] a);
        case (a)
            8'h21, 8'h25, 8'h29: return 8'h0f;
            8'h2d, 8'h31: return 8'h03;
            8'h3c: return 8'h10;
            8'he0: return 8'h01;
            8'he1: return error_mask_used_bits;
            default: return 8'hff;
        endcase
    endfunction : used_bits
    function automatic logic sig(input int k);
        return k == 0 ? video_out.hsync : (k == 1 ? video_out.vsync : video_out.de);
    endfunction : sig
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.access(1'b1, a, d, w);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_host.access(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask : rd
    task automatic run(input int k, input logic v, output int len);
        len = 0;
        while (sig(k) === v && len < 5000) begin
            len++;
            @(negedge clk);
        end
    endtask : run
    task automatic check_video(input int d);
        repeat (70) @(negedge clk);
        repeat (40) begin
            @(negedge clk);
            chk({video_out.de, video_out.pixel}, {hist[10].de, hist[10].pixel});
            chk({video_out.hsync, video_out.vsync}, {hist[d + 10].hsync, hist[d + 10].vsync});
        end
    endtask : check_video
    task automatic final_report();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        for (i = 0; i < 17; i++) begin
            rd(regs[i], reg_reset_value);
            m = 8'($random(seed));
            if (regs[i] == sync_delay_low_addr) m[5] = 1'b1;
            wr(regs[i], m);
            rd(regs[i], m & used_bits(regs[i]));
        end
        rd(error_status_flags_addr, error_status_reset_value);
        wr(8'h00, 8'hff);
        rd(8'h00, 8'h00);
        wr(interrupt_output_enable_addr, 8'h01);
        wr(error_status_flags_addr, 8'h01);
        rd(error_status_flags_addr, 8'h00);
        for (i = 0; i < 6; i++) begin
            b = 8'h80 >> i;
            m = i[0] ? (8'($random(seed)) & ~b) : (8'($random(seed)) | b);
            wr(error_interrupt_mask_addr, m);
            @(negedge clk);
            error_events = error_events_type'(b[7:2]);
            @(negedge clk);
            error_events = '0;
            rd(error_status_flags_addr, b);
            chk(irq_o, |(m & b));
            wr(error_status_flags_addr, ~b);
            rd(error_status_flags_addr, b);
            wr(error_status_flags_addr, b);
            rd(error_status_flags_addr, 8'h00);
        end
        wr(error_interrupt_mask_addr, 8'h01);
        @(negedge clk);
        pll_locked = 1'b0;
        rd(error_status_flags_addr, 8'h01);
        chk(irq_o & irq_oe, 1'b1);
        pll_locked = 1'b1;
        wr(error_status_flags_addr, 8'h01);
        chk(irq_o, 1'b0);
        for (i = 0; i < 16; i++) wr(cfg[i][15:8], cfg[i][7:0]);
        chk(irq_oe, 1'b0);
        check_video(40);
        wr(pattern_control_addr, 8'h10);
        run(1, 1'b1, n);
        run(1, 1'b0, n);
        run(1, 1'b1, n);
        chk(n, 14);
        run(2, 1'b0, n);
        chk(n, 19);
        run(2, 1'b1, n);
        chk(n, 5);
        run(0, 1'b0, n);
        chk(n, 4);
        run(0, 1'b1, n);
        chk(n, 3);
        run(2, 1'b0, n);
        chk(n, 2);
        lines = 1;
        gap = 0;
        pde = 1'b0;
        while (video_out.vsync !== 1'b1) begin
            if (video_out.de === 1'b1 && !pde) lines++;
            pde = video_out.de;
            gap = (video_out.de === 1'b1) ? 0 : gap + 1;
            @(negedge clk);
        end
        chk(lines, 257);
        chk(gap, 18);
        wr(pattern_control_addr, 8'h00);
        check_video(40);
        // second reset in mid-run: enable and mask must fall back, status back to its reset value
        wr(interrupt_output_enable_addr, 8'h01);
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        chk(irq_oe, 1'b0);
        chk(irq_o, 1'b0);
        rd(error_status_flags_addr, error_status_reset_value);
        rd(pattern_control_addr, reg_reset_value);
        rd(error_interrupt_mask_addr, reg_reset_value);
        final_report();
    end
endmodule : tb_top
bind video_timing_irq_csr video_timing_irq_checker i_chk (.clk(clk), .sys_rst(sys_rst),
    .csr_req(csr_req), .csr_rdata(csr_rdata), .video_in(video_in),
    .error_events(error_events), .pll_locked(pll_locked), .video_out(video_out),
    .irq_o(irq_o), .irq_oe(irq_oe));
`default_nettype wire
